/* File: hdl/psw_ctrl.sv */
// Flash program-store write/erase control with key lock
`timescale 1ns/1ps
`default_nettype none
`include "psw_map.svh"
module psw_ctrl
(
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        sfr_wr,
   input  wire logic        sfr_rd,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic [7:0]  sfr_wdata,
   output logic      [7:0]  sfr_rdata,
   input  wire logic        xdata_wr,
   input  wire logic [15:0] xdata_addr,
   input  wire logic [7:0]  xdata_wdata,
   output logic             ram_wr,
   output logic             flash_prog,
   output logic             flash_erase,
   output logic      [15:0] flash_addr,
   output logic      [7:0]  flash_data,
   input  wire logic        flash_done,
   output logic             irq_hold
);
   psw_pkg::psw_state_t st_ff;
   psw_pkg::psw_state_t nxt_st;

   always_comb
   begin
      nxt_st        = st_ff;
      nxt_st.fl_wr  = 1'b0;
      nxt_st.fl_er  = 1'b0;
      nxt_st.ram_wr = 1'b0;
      if (sfr_wr && sfr_addr == `PSW_CTL_ADDR)
      begin
         nxt_st.ctl.we = sfr_wdata[`PSW_WE_BIT];
         nxt_st.ctl.ee = sfr_wdata[`PSW_EE_BIT];
      end
      if (sfr_wr && sfr_addr == `PSW_KEY_ADDR)
      begin
         case (st_ff.lock)
            psw_pkg::LK_LOCKED:
               nxt_st.lock = (sfr_wdata == `PSW_KEY_FIRST) ? psw_pkg::LK_FIRST : psw_pkg::LK_DEAD;
            psw_pkg::LK_FIRST:
               nxt_st.lock = (sfr_wdata == `PSW_KEY_SECOND) ? psw_pkg::LK_OPEN : psw_pkg::LK_DEAD;
            psw_pkg::LK_OPEN:
               nxt_st.lock = psw_pkg::LK_DEAD;
            default:
               nxt_st.lock = psw_pkg::LK_DEAD;
         endcase
      end
      if (sfr_rd)
      begin
         if (sfr_addr == `PSW_CTL_ADDR)
            nxt_st.rdata = {6'h00, st_ff.ctl.ee, st_ff.ctl.we};
         else if (sfr_addr == `PSW_KEY_ADDR)
            nxt_st.rdata = {6'h00, st_ff.lock};
         else
            nxt_st.rdata = 8'h00;
      end
      case (st_ff.op)
         psw_pkg::OP_IDLE:
         begin
            if (xdata_wr)
            begin
               if (!st_ff.ctl.we)
                  nxt_st.ram_wr = 1'b1;
               else if (st_ff.lock == psw_pkg::LK_OPEN)
               begin
                  // Erase needs both enables; data ignored by the array on erase
                  nxt_st.fl_er    = st_ff.ctl.ee;
                  nxt_st.fl_wr    = !st_ff.ctl.ee;
                  nxt_st.addr     = xdata_addr;
                  nxt_st.data     = xdata_wdata;
                  nxt_st.op       = psw_pkg::OP_BUSY;
                  nxt_st.irq_hold = 1'b1;
               end
               else
                  nxt_st.lock = psw_pkg::LK_DEAD;
            end
         end
         psw_pkg::OP_BUSY:
         begin
            if (flash_done)
            begin
               nxt_st.op       = psw_pkg::OP_IDLE;
               nxt_st.irq_hold = 1'b0;
               // Key wins over nothing here: a dead lock stays dead
               if (st_ff.lock == psw_pkg::LK_OPEN)
                  nxt_st.lock = psw_pkg::LK_LOCKED;
            end
         end
         default:
            nxt_st.op = psw_pkg::OP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign sfr_rdata   = st_ff.rdata;
   assign ram_wr      = st_ff.ram_wr;
   assign flash_prog  = st_ff.fl_wr;
   assign flash_erase = st_ff.fl_er;
   assign flash_addr  = st_ff.addr;
   assign flash_data  = st_ff.data;
   assign irq_hold    = st_ff.irq_hold;

   a_ctl_upper_zero: assert property (@(posedge clk) disable iff (!rst_n)
      sfr_rd && sfr_addr == `PSW_CTL_ADDR |=> sfr_rdata[7:2] == 6'h00) else $error("ctl upper bits nonzero");
   a_ctl_readback: assert property (@(posedge clk) disable iff (!rst_n)
      sfr_wr && sfr_addr == `PSW_CTL_ADDR ##1 sfr_rd && sfr_addr == `PSW_CTL_ADDR && !sfr_wr
      |=> sfr_rdata[1:0] == $past(sfr_wdata[1:0], 2)) else $error("ctl readback wrong");
   a_erase_both: assert property (@(posedge clk) disable iff (!rst_n)
      flash_erase |-> $past(st_ff.ctl.we) && $past(st_ff.ctl.ee)) else $error("erase without both enables");
   a_prog_we_only: assert property (@(posedge clk) disable iff (!rst_n)
      flash_prog |-> $past(st_ff.ctl.we) && !$past(st_ff.ctl.ee)) else $error("program with wrong enables");
   a_no_flash_off: assert property (@(posedge clk) disable iff (!rst_n)
      !st_ff.ctl.we && xdata_wr && st_ff.op == psw_pkg::OP_IDLE |=> ram_wr && !flash_prog && !flash_erase)
      else $error("write not routed to ram");
   a_irq_held: assert property (@(posedge clk) disable iff (!rst_n)
      (flash_prog || flash_erase) |-> irq_hold) else $error("irq not held in operation");
   a_key_open: assert property (@(posedge clk) disable iff (!rst_n)
      (flash_prog || flash_erase) |-> $past(st_ff.lock) == psw_pkg::LK_OPEN) else $error("op while not unlocked");
   a_relock_done: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.op == psw_pkg::OP_BUSY && flash_done && st_ff.lock == psw_pkg::LK_OPEN && !sfr_wr
      |=> st_ff.lock == psw_pkg::LK_LOCKED) else $error("no relock after op");
   a_dead_stays: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.lock == psw_pkg::LK_DEAD |=> st_ff.lock == psw_pkg::LK_DEAD) else $error("lock left disabled");
   a_key_read: assert property (@(posedge clk) disable iff (!rst_n)
      sfr_rd && sfr_addr == `PSW_KEY_ADDR |=> sfr_rdata == {6'h00, $past(st_ff.lock)}) else $error("key read wrong");

   // Key steps; a flash attempt in the same cycle wins and kills the lock
   a_first_key: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.lock == psw_pkg::LK_LOCKED && sfr_wr && sfr_addr == `PSW_KEY_ADDR && sfr_wdata == `PSW_KEY_FIRST
      && !(xdata_wr && st_ff.ctl.we && st_ff.op == psw_pkg::OP_IDLE) |=> st_ff.lock == psw_pkg::LK_FIRST)
      else $error("first key not taken");

   a_second_key: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.lock == psw_pkg::LK_FIRST && sfr_wr && sfr_addr == `PSW_KEY_ADDR && sfr_wdata == `PSW_KEY_SECOND
      && !(xdata_wr && st_ff.ctl.we && st_ff.op == psw_pkg::OP_IDLE) |=> st_ff.lock == psw_pkg::LK_OPEN)
      else $error("second key not taken");

   a_wrong_key: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.lock == psw_pkg::LK_LOCKED && sfr_wr && sfr_addr == `PSW_KEY_ADDR && sfr_wdata != `PSW_KEY_FIRST
      |=> st_ff.lock == psw_pkg::LK_DEAD)
      else $error("wrong key did not disable");

   a_open_rekey: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.lock == psw_pkg::LK_OPEN && sfr_wr && sfr_addr == `PSW_KEY_ADDR
      |=> st_ff.lock == psw_pkg::LK_DEAD)
      else $error("key write while open not fatal");

   // Attempt without the key is the hazard the lock exists for
   a_locked_attempt: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.op == psw_pkg::OP_IDLE && xdata_wr && st_ff.ctl.we && st_ff.lock != psw_pkg::LK_OPEN
      |=> st_ff.lock == psw_pkg::LK_DEAD)
      else $error("locked attempt did not disable");

   a_no_erase_off: assert property (@(posedge clk) disable iff (!rst_n)
      !st_ff.ctl.we
      |=> !flash_erase)
      else $error("erase with write enable clear");

   a_no_prog_off: assert property (@(posedge clk) disable iff (!rst_n)
      !st_ff.ctl.we
      |=> !flash_prog)
      else $error("program with write enable clear");

   a_ram_we_off: assert property (@(posedge clk) disable iff (!rst_n)
      ram_wr
      |-> !$past(st_ff.ctl.we) && !flash_prog && !flash_erase)
      else $error("ram write with write enable set");

   // Held until the array reports done; one launch per unlock
   a_irq_stays: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.op == psw_pkg::OP_BUSY && !flash_done
      |=> irq_hold)
      else $error("irq hold dropped early");

   a_irq_release: assert property (@(posedge clk) disable iff (!rst_n)
      st_ff.op == psw_pkg::OP_BUSY && flash_done
      |=> !irq_hold)
      else $error("irq hold not released");

   a_op_pulse: assert property (@(posedge clk) disable iff (!rst_n)
      flash_prog || flash_erase
      |=> !flash_prog && !flash_erase)
      else $error("flash strobe longer than one cycle");

   a_addr_taken: assert property (@(posedge clk) disable iff (!rst_n)
      flash_prog || flash_erase
      |-> flash_addr == $past(xdata_addr) && flash_data == $past(xdata_wdata))
      else $error("flash address or data not captured");
endmodule : psw_ctrl
`default_nettype wire

/* File: pkg/psw_map.svh */
// Register offsets, field positions, reset values and key codes for the flash write control
`ifndef PSW_MAP_SVH
`define PSW_MAP_SVH
`define PSW_CTL_ADDR    8'h8f
`define PSW_KEY_ADDR    8'hb7
`define PSW_CTL_RESET   8'h00
`define PSW_WE_BIT      0
`define PSW_EE_BIT      1
`define PSW_KEY_FIRST   8'ha5
`define PSW_KEY_SECOND  8'hf1
`define PSW_LK_LOCKED   2'h0
`define PSW_LK_FIRST    2'h1
`define PSW_LK_OPEN     2'h2
`define PSW_LK_DEAD     2'h3
`endif

/* File: pkg/psw_pkg.sv */
// Types for the flash write control block
`default_nettype none
package psw_pkg;
   typedef enum logic [1:0] {LK_LOCKED, LK_FIRST, LK_OPEN, LK_DEAD} psw_lock_t;
   typedef enum logic [1:0] {OP_IDLE, OP_BUSY} psw_op_t;
   typedef struct packed {
      logic       we;
      logic       ee;
   } psw_ctl_t;
   typedef struct packed {
      psw_ctl_t   ctl;
      psw_lock_t  lock;
      psw_op_t    op;
      logic [7:0] rdata;
      logic       irq_hold;
      logic       fl_wr;
      logic       fl_er;
      logic       ram_wr;
      logic [15:0] addr;
      logic [7:0] data;
   } psw_state_t;
endpackage : psw_pkg
`default_nettype wire

/* File: verification/psw_ctrl_test.sv */
// Self-checking bench for the flash write control block
`timescale 1ns/1ps
`default_nettype none
`include "psw_map.svh"
module psw_ctrl_test;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        sfr_wr = 1'b0;
   logic        sfr_rd = 1'b0;
   logic        xdata_wr = 1'b0;
   logic        flash_done = 1'b0;
   logic [7:0]  sfr_addr = 8'h00;
   logic [7:0]  sfr_wdata = 8'h00;
   logic [7:0]  xdata_wdata = 8'h00;
   logic [15:0] xdata_addr = 16'h0000;
   logic        ram_wr, flash_prog, flash_erase, irq_hold, rd_d;
   logic [7:0]  sfr_rdata, flash_data;
   logic [15:0] flash_addr;
   logic [31:0] exp_q[$];
   logic [31:0] seen;
   int          n_fail = 0;
   int          total_checks = 0;
   int          r;
   psw_ctrl psw_ctrl_inst (.clk(clk), .rst_n(rst_n), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .xdata_wr(xdata_wr), .xdata_addr(xdata_addr),
      .xdata_wdata(xdata_wdata), .ram_wr(ram_wr), .flash_prog(flash_prog), .flash_erase(flash_erase),
      .flash_addr(flash_addr), .flash_data(flash_data), .flash_done(flash_done), .irq_hold(irq_hold));
   initial
   begin
      forever #5 clk = ~clk;
   end
   task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask : chk
   task automatic end_of_test;
      if (n_fail == 0 && total_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      sfr_wr <= 1'b1;
      sfr_addr <= a;
      sfr_wdata <= d;
      @(posedge clk);
      sfr_wr <= 1'b0;
   endtask : sfr_w
   task automatic sfr_r(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back({8'h04, 16'h0000, e});
      @(posedge clk);
      sfr_rd <= 1'b1;
      sfr_addr <= a;
      @(posedge clk);
      sfr_rd <= 1'b0;
   endtask : sfr_r
   task automatic key(input logic [7:0] d, input logic [1:0] st);
      sfr_w(`PSW_KEY_ADDR, d);
      sfr_r(`PSW_KEY_ADDR, {6'h00, st});
   endtask : key
   // Kind 0 none, 1 data RAM, 2 program, 3 erase; erase data is don't care
   task automatic xw(input logic [7:0] kind);
      logic [15:0] a;
      logic [7:0]  d;
      a = 16'($urandom);
      d = 8'($urandom);
      if (kind != 8'h00)
         exp_q.push_back({kind, (kind > 8'h01) ? a : 16'h0000, (kind == 8'h02) ? d : 8'h00});
      @(posedge clk);
      xdata_wr <= 1'b1;
      xdata_addr <= a;
      xdata_wdata <= d;
      @(posedge clk);
      xdata_wr <= 1'b0;
      if (kind > 8'h01)
      begin
         @(negedge clk);
         chk("irq_hold busy", 32'h1, {31'h0, irq_hold});
         @(posedge clk);
         flash_done <= 1'b1;
         @(posedge clk);
         flash_done <= 1'b0;
         @(posedge clk);
         @(negedge clk);
         chk("irq_hold done", 32'h0, {31'h0, irq_hold});
      end
   endtask : xw
   always @(posedge clk) rd_d <= sfr_rd;
   // Results are matched in order; a stray pulse with nothing queued is a failure
   always @(negedge clk)
   begin
      if (rd_d === 1'b1 || ram_wr === 1'b1 || flash_prog === 1'b1 || flash_erase === 1'b1)
      begin
         seen = (rd_d === 1'b1) ? {8'h04, 16'h0000, sfr_rdata} : (ram_wr === 1'b1) ? 32'h01000000 :
            (flash_prog === 1'b1) ? {8'h02, flash_addr, flash_data} : {8'h03, flash_addr, 8'h00};
         chk("result", (exp_q.size() > 0) ? exp_q.pop_front() : 32'h0, seen);
      end
   end
   initial
   begin
      r = $urandom(51);
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      sfr_r(`PSW_CTL_ADDR, `PSW_CTL_RESET);
      sfr_r(`PSW_KEY_ADDR, {6'h00, `PSW_LK_LOCKED});
      sfr_w(`PSW_CTL_ADDR, 8'hff);
      sfr_r(`PSW_CTL_ADDR, 8'h03);
      sfr_w(`PSW_CTL_ADDR, 8'h02);
      xw(8'h01);
      sfr_w(`PSW_CTL_ADDR, 8'h00);
      xw(8'h01);
      for (int k = 0; k < 4; k++)
      begin
         // Supply and clock duties have no pins here; interrupts are held off through irq_hold
         sfr_w(`PSW_CTL_ADDR, (k == 0) ? 8'h03 : 8'h01);
         key(`PSW_KEY_FIRST, `PSW_LK_FIRST);
         key(`PSW_KEY_SECOND, `PSW_LK_OPEN);
         xw((k == 0) ? 8'h03 : 8'h02);
         sfr_r(`PSW_KEY_ADDR, {6'h00, `PSW_LK_LOCKED});
      end
      xw(8'h00);
      sfr_r(`PSW_KEY_ADDR, {6'h00, `PSW_LK_DEAD});
      key(`PSW_KEY_FIRST, `PSW_LK_DEAD);
      key(`PSW_KEY_SECOND, `PSW_LK_DEAD);
      xw(8'h00);
      rst_n <= 1'b0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      sfr_r(`PSW_CTL_ADDR, `PSW_CTL_RESET);
      key(8'h5a, `PSW_LK_DEAD);
      for (int i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
      chk("pending", 32'h0, 32'(exp_q.size()));
      end_of_test();
   end
endmodule : psw_ctrl_test
`default_nettype wire
